/* src/lpsdram_regs.svh */
// Timing and encoding constants for the low-power DRAM read-path model.
`ifndef LPSDRAM_REGS_SVH
`define LPSDRAM_REGS_SVH
`define CLK_PERIOD_NS 20
`define SAME_BANK_ACTIVATE_PERIOD_NS 60
`define ACTIVATE_TO_ACCESS_NS 18
`define CROSS_BANK_ACTIVATE_GAP_NS 12
`define PRECHARGE_PERIOD_NS 18
`define MODE_LOAD_TO_ACTIVATE_GAP_CLK 2
`define LAST_WDATA_TO_ACCESS_GAP_CLK 1
`define LAST_WDATA_TO_PRECHARGE_GAP_CLK 2
`define OUTPUT_MASK_LATENCY_CLK 2
`define CAS_LATENCY_RESET 2'h2
`define BURST_LEN_RESET 3'h2
`define BURST_FULL_PAGE 3'h7
`define AUTO_PRECHARGE_BIT 10
`endif

/* src/lpsdram_pkg.sv */
// Types shared by the low-power DRAM read-path model.
package lpsdram_pkg;
  // Command bus as sampled on a rising edge: chip select, row/column strobe, write enable, all active low.
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } cmd_pins_t;
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACTIVATE = 3'h1,
    CMD_READ = 3'h2,
    CMD_WRITE = 3'h3,
    CMD_PRECHARGE = 3'h4,
    CMD_TERMINATE = 3'h5,
    CMD_MODE_LOAD = 3'h6,
    CMD_REFRESH = 3'h7
  } cmd_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_BURST = 2'h1,
    RD_DRAIN = 2'h2
  } rd_state_t;
endpackage

/* src/lpsdram_activate_read_burst.sv */
// Read-path and activation logic of a low-power synchronous DRAM.
`timescale 1ns/1ps
`include "lpsdram_regs.svh"
module lpsdram_activate_read_burst #(
  parameter int DATA_W = 32,
  parameter int COL_W = 9,
  parameter int ROW_W = 13,
  parameter int BANKS = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire lpsdram_pkg::cmd_pins_t cmd_pins,
  input wire logic cke,
  input wire logic [$clog2(BANKS)-1:0] bank_addr,
  input wire logic [ROW_W-1:0] addr,
  input wire logic dqm,
  input wire logic [1:0] cas_latency_setting,
  input wire logic [2:0] burst_len_code,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic [ROW_W-1:0] rd_row,
  output logic [$clog2(BANKS)-1:0] rd_bank,
  output logic [COL_W-1:0] rd_col,
  output logic rd_fetch,
  input wire logic [DATA_W-1:0] rd_data,
  output logic wr_strobe,
  output logic [DATA_W-1:0] wr_data,
  output logic [COL_W-1:0] wr_col,
  output logic [$clog2(BANKS)-1:0] wr_bank,
  output logic [BANKS-1:0] row_open,
  output logic access_violation
);
  localparam int BW = $clog2(BANKS);
  localparam int TRCD_CLK = (`ACTIVATE_TO_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int TRC_CLK = (`SAME_BANK_ACTIVATE_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int CROSS_BANK_ACTIVATE_GAP_CLK = (`CROSS_BANK_ACTIVATE_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int TRP_CLK = (`PRECHARGE_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  // Decode the four strobes into a command; a low clock enable masks the edge.
  function automatic lpsdram_pkg::cmd_t decode(input lpsdram_pkg::cmd_pins_t p, input logic en);
    lpsdram_pkg::cmd_t c;
    c = lpsdram_pkg::CMD_NOP;
    if (en && !p.cs_n)
    begin
      unique case ({p.ras_n, p.cas_n, p.we_n})
        3'h3: c = lpsdram_pkg::CMD_ACTIVATE;
        3'h5: c = lpsdram_pkg::CMD_READ;
        3'h4: c = lpsdram_pkg::CMD_WRITE;
        3'h2: c = lpsdram_pkg::CMD_PRECHARGE;
        3'h6: c = lpsdram_pkg::CMD_TERMINATE;
        3'h0: c = lpsdram_pkg::CMD_MODE_LOAD;
        3'h1: c = lpsdram_pkg::CMD_REFRESH;
        default: c = lpsdram_pkg::CMD_NOP;
      endcase
    end
    return c;
  endfunction

  // Burst length in elements, zero meaning full page.
  function automatic logic [COL_W:0] burst_elems(input logic [2:0] code);
    logic [COL_W:0] n;
    n = '0;
    if (code != `BURST_FULL_PAGE)
    begin
      n = (COL_W+1)'(1) << code[1:0];
    end
    return n;
  endfunction

  lpsdram_pkg::cmd_t cmd;
  assign cmd = decode(cmd_pins, cke);

  // ****************************************************************
  // Bank state
  // ****************************************************************
  logic [BANKS-1:0] open_reg, open_next;
  logic [ROW_W-1:0] row_reg [BANKS], row_next [BANKS];
  logic [3:0] busy_reg [BANKS], busy_next [BANKS];
  logic viol_reg, viol_next;

  // Activate opens a row; precharge closes one or all. Early accesses are flagged, not blocked.
  always_comb
  begin
    open_next = open_reg;
    viol_next = 1'b0;
    for (int b = 0; b < BANKS; b++)
    begin
      row_next[b] = row_reg[b];
      busy_next[b] = (busy_reg[b] != 4'h0) ? busy_reg[b] - 4'h1 : 4'h0;
    end
    if (cmd == lpsdram_pkg::CMD_ACTIVATE)
    begin
      open_next[bank_addr] = 1'b1;
      row_next[bank_addr] = addr;
      busy_next[bank_addr] = 4'(TRCD_CLK - 1);
    end
    if ((cmd == lpsdram_pkg::CMD_READ || cmd == lpsdram_pkg::CMD_WRITE) &&
        (!open_reg[bank_addr] || busy_reg[bank_addr] != 4'h0))
    begin
      viol_next = 1'b1;
    end
    if (cmd == lpsdram_pkg::CMD_PRECHARGE)
    begin
      for (int b = 0; b < BANKS; b++)
      begin
        if (addr[`AUTO_PRECHARGE_BIT] || bank_addr == BW'(b))
        begin
          open_next[b] = 1'b0;
          busy_next[b] = 4'(TRP_CLK - 1);
        end
      end
    end
  end

  // Bank state registers.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      open_reg <= '0;
      viol_reg <= 1'b0;
      for (int b = 0; b < BANKS; b++)
      begin
        row_reg[b] <= '0;
        busy_reg[b] <= 4'h0;
      end
    end
    else
    begin
      open_reg <= open_next;
      viol_reg <= viol_next;
      row_reg <= row_next;
      busy_reg <= busy_next;
    end
  end

  // ****************************************************************
  // Read burst engine
  // ****************************************************************
  lpsdram_pkg::rd_state_t st_reg, st_next;
  logic [COL_W-1:0] col_reg, col_next;
  logic [BW-1:0] bank_reg, bank_next;
  logic [COL_W:0] left_reg, left_next;
  logic ap_reg, ap_next;
  logic [1:0] drain_reg, drain_next;
  // Per-stage pipe: valid flag indexed by latency stage; the per-stage mask bits stay zero, and masking comes from dqm_reg.
  logic [3:0] pv_reg, pv_next;
  logic [3:0] pm_reg, pm_next;
  logic [DATA_W-1:0] pd_reg [4], pd_next [4];
  logic [1:0] dqm_reg, dqm_next;
  logic [DATA_W-1:0] dq_reg, dq_next;
  logic oe_reg, oe_next;
  logic issue;

  // Fetch one element per cycle while bursting or draining; data is aligned by the latency pipe.
  always_comb
  begin
    st_next = st_reg;
    col_next = col_reg;
    bank_next = bank_reg;
    left_next = left_reg;
    ap_next = ap_reg;
    drain_next = drain_reg;
    issue = 1'b0;
    dqm_next = {dqm_reg[0], dqm};
    if (cmd == lpsdram_pkg::CMD_READ)
    begin
      // The read edge fetches the first element itself, so the counter holds only the rest.
      st_next = (burst_elems(burst_len_code) == (COL_W+1)'(1)) ? lpsdram_pkg::RD_IDLE :
                lpsdram_pkg::RD_BURST;
      col_next = addr[COL_W-1:0];
      bank_next = bank_addr;
      ap_next = addr[`AUTO_PRECHARGE_BIT];
      left_next = (burst_elems(burst_len_code) == '0) ? '0 :
                  burst_elems(burst_len_code) - (COL_W+1)'(1);
      issue = 1'b1;
    end
    else if (cmd == lpsdram_pkg::CMD_WRITE || cmd == lpsdram_pkg::CMD_TERMINATE)
    begin
      st_next = lpsdram_pkg::RD_IDLE;
    end
    else if (cmd == lpsdram_pkg::CMD_PRECHARGE && st_reg == lpsdram_pkg::RD_BURST)
    begin
      // Fetching stops at the precharge edge; what is already in the latency pipe still comes out,
      // so the pins float CL clocks after the precharge.
      st_next = lpsdram_pkg::RD_IDLE;
    end
    else if (st_reg == lpsdram_pkg::RD_BURST)
    begin
      issue = 1'b1;
      if (left_reg == (COL_W+1)'(1))
      begin
        st_next = lpsdram_pkg::RD_IDLE;
      end
      if (left_reg != '0)
      begin
        left_next = left_reg - (COL_W+1)'(1);
      end
    end
    else if (st_reg == lpsdram_pkg::RD_DRAIN)
    begin
      issue = 1'b1;
      drain_next = drain_reg - 2'h1;
      if (drain_reg == 2'h0)
      begin
        st_next = lpsdram_pkg::RD_IDLE;
      end
    end
    if (issue && cmd != lpsdram_pkg::CMD_READ)
    begin
      col_next = col_reg + COL_W'(1);
    end
    if (st_reg == lpsdram_pkg::RD_IDLE && cmd != lpsdram_pkg::CMD_READ)
    begin
      st_next = lpsdram_pkg::RD_IDLE;
    end
  end

  // Requested element address; wraps naturally at the page end.
  assign rd_fetch = issue;
  assign rd_col = (cmd == lpsdram_pkg::CMD_READ) ? addr[COL_W-1:0] :
                  (issue ? col_reg + COL_W'(1) : col_reg);
  assign rd_bank = (cmd == lpsdram_pkg::CMD_READ) ? bank_addr : bank_reg;
  assign rd_row = row_reg[rd_bank];

  // Latency pipe: element fetched at the command edge appears CL edges later.
  always_comb
  begin
    pv_next = {pv_reg[2:0], issue};
    pm_next = pm_reg;
    pd_next[0] = rd_data;
    for (int i = 1; i < 4; i++)
    begin
      pd_next[i] = pd_reg[i-1];
    end
    // A write drops all read data still in flight and frees the pins.
    if (cmd == lpsdram_pkg::CMD_WRITE)
    begin
      pv_next = 4'h0;
    end
    // Output masking two clocks after the mask pin is sampled.
    dq_next = pd_reg[cas_latency_setting - 2'h1];
    oe_next = pv_reg[cas_latency_setting - 2'h1] && !dqm_reg[1] && cmd != lpsdram_pkg::CMD_WRITE;
  end

  // Read engine and output registers.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_reg <= lpsdram_pkg::RD_IDLE;
      col_reg <= '0;
      bank_reg <= '0;
      left_reg <= '0;
      ap_reg <= 1'b0;
      drain_reg <= 2'h0;
      pv_reg <= 4'h0;
      pm_reg <= 4'h0;
      dqm_reg <= 2'h0;
      dq_reg <= '0;
      oe_reg <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        pd_reg[i] <= '0;
      end
    end
    else
    begin
      st_reg <= st_next;
      col_reg <= col_next;
      bank_reg <= bank_next;
      left_reg <= left_next;
      ap_reg <= ap_next;
      drain_reg <= drain_next;
      pv_reg <= pv_next;
      pm_reg <= pm_next;
      dqm_reg <= dqm_next;
      dq_reg <= dq_next;
      oe_reg <= oe_next;
      pd_reg <= pd_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Write data is taken on the command edge; the mask applies with zero latency.
  assign wr_strobe = (cmd == lpsdram_pkg::CMD_WRITE) && !dqm;
  assign wr_data = dq_in;
  assign wr_col = addr[COL_W-1:0];
  assign wr_bank = bank_addr;
  assign dq_out = dq_reg;
  assign dq_oe = oe_reg;
  assign row_open = open_reg;
  assign access_violation = viol_reg;
endmodule // lpsdram_activate_read_burst

/* testbench/lpsdram_activate_read_burst_assertions.sv */
// Port checker for the DRAM read path.
`timescale 1ns/1ps
// ****
// Checker
// ****
module lpsdram_arb_checker #(
  parameter int DATA_W = 32,
  parameter int COL_W = 9,
  parameter int ROW_W = 13,
  parameter int BANKS = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire lpsdram_pkg::cmd_pins_t cmd_pins,
  input wire logic cke,
  input wire logic [$clog2(BANKS)-1:0] bank_addr,
  input wire logic [ROW_W-1:0] addr,
  input wire logic dqm,
  input wire logic [1:0] cas_latency_setting,
  input wire logic [2:0] burst_len_code,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic [COL_W-1:0] rd_col,
  input wire logic rd_fetch,
  input wire logic wr_strobe,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [BANKS-1:0] row_open,
  input wire logic access_violation
);
  logic act;
  logic rd;
  logic wr;
  logic pre;
  logic nop;
  // Decode; a low clock enable turns the edge into a no-operation.
  assign act = cke && (cmd_pins == 4'h3);
  assign rd = cke && (cmd_pins == 4'h5);
  assign wr = cke && (cmd_pins == 4'h4);
  assign pre = cke && (cmd_pins == 4'h2);
  assign nop = !cke || cmd_pins.cs_n || (cmd_pins == 4'h7);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_fetch_start_col: assert property (rd |-> rd_fetch && rd_col == addr[COL_W-1:0])
    else $error("read fetch column wrong");
  a_first_data_two: assert property ((rd && cas_latency_setting == 2'h2) ##1 nop [*2] |=>
    dq_oe && dq_out == $past(rd_data, 3)) else $error("first element wrong at latency two");
  a_first_data_three: assert property ((rd && cas_latency_setting == 2'h3) ##1 nop [*3] |=>
    dq_oe && dq_out == $past(rd_data, 4)) else $error("first element wrong at latency three");
  a_single_burst_ends: assert property ((rd && cas_latency_setting == 2'h2 && burst_len_code == 3'h0)
    ##1 nop [*3] |=> !dq_oe) else $error("single burst still driving");
  a_write_floats_bus: assert property (wr |=> !dq_oe) else $error("bus driven after write");
  a_write_mask_now: assert property (wr |-> wr_strobe != dqm && (dqm || wr_data == dq_in))
    else $error("write mask or data wrong");
  a_precharge_float: assert property ((pre && cas_latency_setting == 2'h2) ##1 nop [*2] |=> !dq_oe)
    else $error("no float after precharge");
  a_activate_opens: assert property (act |=> row_open[$past(bank_addr)]) else $error("row not open");
  a_closed_flagged: assert property (rd && !row_open[bank_addr] |=> access_violation)
    else $error("closed bank read not flagged");
endmodule // lpsdram_arb_checker

/* testbench/lpsdram_ctrl_model.sv */
// Behavioural memory controller driving the command pins.
`timescale 1ns/1ps
// ****
// Controller model
// ****
module lpsdram_ctrl_model (
  input wire logic clk,
  output lpsdram_pkg::cmd_pins_t cmd_pins,
  output logic cke,
  output logic [1:0] bank_addr,
  output logic [12:0] addr,
  output logic dqm,
  output logic [31:0] dq_in
);
  // Idle no-operation with the clock enable held high; no mode load is ever sent.
  initial
  begin
    cmd_pins = 4'h7;
    cke = 1'b1;
    bank_addr = 2'h0;
    addr = 13'h0000;
    dqm = 1'b0;
    dq_in = 32'h0000_0000;
  end
  // Released bank, address and data lines show their inverse so a stale value never passes for fresh; the command pins return to no-operation.
  task automatic issue(input lpsdram_pkg::cmd_t c, input logic [1:0] b, input logic [12:0] a, input logic [31:0] d);
    case (c)
      lpsdram_pkg::CMD_ACTIVATE: cmd_pins = 4'h3;
      lpsdram_pkg::CMD_READ: cmd_pins = 4'h5;
      lpsdram_pkg::CMD_WRITE: cmd_pins = 4'h4;
      lpsdram_pkg::CMD_PRECHARGE: cmd_pins = 4'h2;
      lpsdram_pkg::CMD_TERMINATE: cmd_pins = 4'h6;
      default: cmd_pins = 4'h7;
    endcase
    bank_addr = b;
    addr = a;
    dq_in = d;
    @(posedge clk);
    #1;
    cmd_pins = 4'h7;
    bank_addr = ~b;
    addr = ~a;
    dq_in = ~d;
  endtask
  // Mask level; changed only just after an edge.
  task automatic set_mask(input logic m);
    dqm = m;
  endtask
endmodule // lpsdram_ctrl_model

/* testbench/lpsdram_activate_read_burst_bench.sv */
// Self-checking bench for the DRAM read path.
`timescale 1ns/1ps
// ****
// Bench
// ****
module lpsdram_activate_read_burst_bench;
  logic clk;
  logic sys_rst;
  logic [1:0] cas_latency_setting;
  logic [2:0] burst_len_code;
  lpsdram_pkg::cmd_pins_t cmd_pins;
  logic cke;
  logic [1:0] bank_addr;
  logic [12:0] addr;
  logic dqm;
  logic [31:0] dq_in;
  logic [31:0] dq_out;
  logic dq_oe;
  logic [1:0] rd_bank;
  logic [8:0] rd_col;
  logic [31:0] rd_data;
  logic wr_strobe;
  logic [31:0] wr_data;
  logic [3:0] row_open;
  logic access_violation;
  int n_errors = 0;
  int n_compared = 0;
  // Array contents follow bank and column, so each element is traceable.
  function automatic logic [31:0] pat(input logic [1:0] b, input logic [8:0] c);
    return {16'hC0DE, 1'b0, b, 4'h0, c};
  endfunction
  assign rd_data = pat(rd_bank, rd_col);
  lpsdram_ctrl_model ctl (.clk(clk), .cmd_pins(cmd_pins), .cke(cke), .bank_addr(bank_addr), .addr(addr),
    .dqm(dqm), .dq_in(dq_in));
  lpsdram_activate_read_burst dut (.clk(clk), .sys_rst(sys_rst), .cmd_pins(cmd_pins), .cke(cke),
    .bank_addr(bank_addr), .addr(addr), .dqm(dqm), .cas_latency_setting(cas_latency_setting),
    .burst_len_code(burst_len_code), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .rd_row(), .rd_bank(rd_bank),
    .rd_col(rd_col), .rd_fetch(), .rd_data(rd_data), .wr_strobe(wr_strobe), .wr_data(wr_data), .wr_col(),
    .wr_bank(), .row_open(row_open), .access_violation(access_violation));
  // Free-running 50 MHz clock, never stopped or changed; no self refresh is entered.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Checks n consecutive elements, one per clock, wrapping inside the page.
  task automatic burst(input logic [1:0] b, input logic [8:0] c, input int n);
    for (int i = 0; i < n; i++)
    begin
      check(32'(dq_oe), 32'h1);
      check(dq_out, pat(b, c + 9'(i)));
      step(1);
    end
  endtask
  task automatic sc_latency();
    for (int cl = 1; cl <= 3; cl++)
    begin
      cas_latency_setting = 2'(cl);
      burst_len_code = (cl == 2) ? 3'h0 : 3'(cl);
      ctl.issue(lpsdram_pkg::CMD_ACTIVATE, 2'h1, 13'h0123, 32'h0);
      ctl.issue(lpsdram_pkg::CMD_READ, 2'h1, 13'h0005, 32'h0);
      repeat (cl)
      begin
        check(32'(dq_oe), 32'h0);
        step(1);
      end
      burst(2'h1, 9'h005, 1 << burst_len_code);
      check(32'(dq_oe), 32'h0);
      ctl.issue(lpsdram_pkg::CMD_PRECHARGE, 2'h1, 13'h0000, 32'h0);
      step(2);
    end
  endtask
  // Second read one clock before the last element: no gap between bursts.
  task automatic sc_chain();
    cas_latency_setting = 2'h2;
    burst_len_code = 3'h2;
    ctl.issue(lpsdram_pkg::CMD_ACTIVATE, 2'h2, 13'h0044, 32'h0);
    ctl.issue(lpsdram_pkg::CMD_READ, 2'h2, 13'h0010, 32'h0);
    step(2);
    burst(2'h2, 9'h010, 1);
    check(dq_out, pat(2'h2, 9'h011));
    ctl.issue(lpsdram_pkg::CMD_READ, 2'h2, 13'h0040, 32'h0);
    burst(2'h2, 9'h012, 2);
    burst(2'h2, 9'h040, 4);
    check(32'(dq_oe), 32'h0);
  endtask
  // Full page from the page end, cut by precharge two clocks before the last.
  task automatic sc_precharge();
    cas_latency_setting = 2'h3;
    burst_len_code = 3'h7;
    ctl.issue(lpsdram_pkg::CMD_ACTIVATE, 2'h3, 13'h0777, 32'h0);
    ctl.issue(lpsdram_pkg::CMD_READ, 2'h3, 13'h01FE, 32'h0);
    step(2);
    ctl.issue(lpsdram_pkg::CMD_PRECHARGE, 2'h3, 13'h0000, 32'h0);
    burst(2'h3, 9'h1FE, 3);
    check(32'(dq_oe), 32'h0);
    check(32'(row_open[3]), 32'h0);
  endtask
  // Mask raised early, then a masked and an unmasked write cut the read.
  task automatic sc_write_cut();
    cas_latency_setting = 2'h2;
    ctl.issue(lpsdram_pkg::CMD_ACTIVATE, 2'h0, 13'h0100, 32'h0);
    ctl.issue(lpsdram_pkg::CMD_READ, 2'h0, 13'h0020, 32'h0);
    ctl.set_mask(1'b1);
    step(3);
    fork
      ctl.issue(lpsdram_pkg::CMD_WRITE, 2'h0, 13'h0030, 32'hA5A5_0001);
      begin
        #2;
        check(32'(wr_strobe), 32'h0);
      end
    join
    check(32'(dq_oe), 32'h0);
    ctl.set_mask(1'b0);
    fork
      ctl.issue(lpsdram_pkg::CMD_WRITE, 2'h0, 13'h0031, 32'h1234_5678);
      begin
        #2;
        check(32'(wr_strobe), 32'h1);
        check(wr_data, 32'h1234_5678);
      end
    join
    step(2);
    check(32'(dq_oe), 32'h0);
  endtask
  // Read to a precharged bank is flagged; only banks 0 and 2 remain open.
  task automatic sc_closed();
    check(32'(row_open), 32'h5);
    ctl.issue(lpsdram_pkg::CMD_READ, 2'h1, 13'h0000, 32'h0);
    check(32'(access_violation), 32'h1);
    ctl.issue(lpsdram_pkg::CMD_TERMINATE, 2'h1, 13'h0000, 32'h0);
    step(1);
    check(dq_out, pat(2'h1, 9'h000));
    step(1);
    check(32'(dq_oe), 32'h0);
    step(6);
  endtask
  task automatic print_verdict();
    $display("compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Reset for eight clocks, then the scenarios in turn.
  initial
  begin
    sys_rst = 1'b1;
    cas_latency_setting = 2'h2;
    burst_len_code = 3'h1;
    repeat (8) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    sc_latency();
    sc_chain();
    sc_precharge();
    sc_write_cut();
    sc_closed();
    print_verdict();
  end
endmodule // lpsdram_activate_read_burst_bench
bind lpsdram_activate_read_burst lpsdram_arb_checker #(.DATA_W(DATA_W), .COL_W(COL_W), .ROW_W(ROW_W),
  .BANKS(BANKS)) chk (.clk(clk), .sys_rst(sys_rst), .cmd_pins(cmd_pins), .cke(cke), .bank_addr(bank_addr),
  .addr(addr), .dqm(dqm), .cas_latency_setting(cas_latency_setting), .burst_len_code(burst_len_code),
  .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .rd_data(rd_data), .rd_col(rd_col), .rd_fetch(rd_fetch),
  .wr_strobe(wr_strobe), .wr_data(wr_data), .row_open(row_open), .access_violation(access_violation));
